// ===== include/cogen_pkg.sv
// cogen_pkg: register map, field layout, types and override encodings for the complementary generator
// assumes a plain register port with 8-bit data and one clock at 50 MHz
package cogen_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [3:0] COGEN_ADDR_RISE_SEL  = 4'h0;
   localparam logic [3:0] COGEN_ADDR_SHUTDOWN  = 4'h1;
   localparam logic [3:0] COGEN_ADDR_CONTROL   = 4'h2;
   localparam logic [3:0] COGEN_ADDR_FALL_SEL  = 4'h3;
   localparam logic [3:0] COGEN_ADDR_DEAD_RISE = 4'h4;
   localparam logic [3:0] COGEN_ADDR_DEAD_FALL = 4'h5;
   localparam logic [3:0] COGEN_ADDR_BLANK_RISE = 4'h6;
   localparam logic [3:0] COGEN_ADDR_BLANK_FALL = 4'h7;
   localparam logic [3:0] COGEN_ADDR_PHASE     = 4'h8;
   localparam logic [3:0] COGEN_ADDR_CLK_DIV   = 4'h9;

   // ------------------------------------------------------------
   // widths, masks and reset values
   // ------------------------------------------------------------
   localparam int         COGEN_SRC_N       = 7;
   localparam logic [7:0] COGEN_RESET_VALUE = 8'h00;
   localparam logic [7:0] COGEN_RISE_MASK   = 8'h7f;
   localparam logic [7:0] COGEN_SHUT_MASK   = 8'hfc;
   localparam logic [7:0] COGEN_CTRL_MASK   = 8'h0f;
   localparam logic [7:0] COGEN_COUNT_ZERO  = 8'h00;
   localparam logic [7:0] COGEN_COUNT_ONE   = 8'h01;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int COGEN_SHUT_FLAG_BIT    = 7;
   localparam int COGEN_SHUT_RESTART_BIT = 6;
   localparam int COGEN_SHUT_CH1_LO      = 4;
   localparam int COGEN_SHUT_CH0_LO      = 2;
   localparam int COGEN_CTRL_ENABLE_BIT  = 0;
   localparam int COGEN_CTRL_MODE_BIT    = 1;
   localparam int COGEN_CTRL_POL0_BIT    = 2;
   localparam int COGEN_CTRL_POL1_BIT    = 3;

   // ------------------------------------------------------------
   // override encodings
   // ------------------------------------------------------------
   localparam logic [1:0] COGEN_OVR_LOW      = 2'h0;
   localparam logic [1:0] COGEN_OVR_HIGH     = 2'h1;
   localparam logic [1:0] COGEN_OVR_INACTIVE = 2'h2;
   localparam logic [1:0] COGEN_OVR_TRISTATE = 2'h3;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cogen_bus_s;

   typedef struct packed {
      logic level;
      logic oe_n;
   } cogen_pin_s;

   typedef enum logic [1:0] {
      COGEN_IDLE,
      COGEN_PHASE,
      COGEN_ACTIVE
   } cogen_state_e;

endpackage

// ===== logic/cogen_top.sv
// cogen_top: complementary output generator with push-pull, dead band, blanking,
// phase delay and auto-shutdown
// assumes event sources and shutdown source arrive unsynchronised from outside
//
// Contract
// - complementary mode drives complementary pair from events
// - rising event starts each output period
// - rise-to-fall interval sets active portion
// - same source may serve rise and fall
// - sync or async event sources accepted
// - delays counted on selectable generator clock
// - dead band delays each turn-on after other
// - push-pull alternates one pulse per period
// - push-pull drive from rise to fall
// - each rise swaps push-pull channel
// - mode bit selects push-pull else complementary
// - blanking ignores opposite event after edge
// - phase timer delays drive after rise
// - shutdown drops drive at once, ahead of the fall event
// - shutdown flag reads one from shutdown until cleared or auto-restarted
// - rise enable bit adds its source
// - rise enable bit order fixed per source
`timescale 1ns/10ps

module cogen_top (
   // clock and reset
   input  wire  logic                   clk_in,
   input  wire  logic                   reset_n_in,
   // register port
   input  wire  cogen_pkg::cogen_bus_s  bus_in,
   output logic [7:0]                   rdata_out,
   // event sources, bit order as the rise select register
   input  wire  logic [6:0]             event_src_in,
   input  wire  logic                   shutdown_src_in,
   // output channels
   output cogen_pkg::cogen_pin_s        output_channel_0_out,
   output cogen_pkg::cogen_pin_s        output_channel_1_out
);
   import cogen_pkg::*;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0]   rising_event_source_select;
   logic [7:0]   falling_event_source_select;
   logic [7:0]   auto_shutdown_control_0;
   logic [7:0]   control;
   logic [7:0]   dead_rise;
   logic [7:0]   dead_fall;
   logic [7:0]   blank_rise;
   logic [7:0]   blank_fall;
   logic [7:0]   phase_count;
   logic [7:0]   clk_div;
   logic [6:0]   src_meta;
   logic [6:0]   src_sync;
   logic [6:0]   src_prev;
   logic         shut_meta;
   logic         shut_sync;
   logic [7:0]   div_cnt;
   logic         tick;
   cogen_state_e state;
   logic [7:0]   phase_cnt;
   logic [7:0]   blank_cnt;
   logic         blank_is_fall;
   logic         drive;
   logic         steer;
   logic [7:0]   dead0_cnt;
   logic [7:0]   dead1_cnt;
   logic         shutdown_flag;
   logic         shut_active;
   logic         ch0_on;
   logic         ch1_on;

   logic [6:0]   src_rise_edge;
   logic         rise_ev;
   logic         fall_ev;
   logic         enable;
   logic         pushpull_mode_select;
   logic         want0;
   logic         want1;
   logic         next_ch0_on;
   logic         next_ch1_on;
   logic         sw_clear_flag;
   logic         resume;

   assign enable               = control[COGEN_CTRL_ENABLE_BIT];
   assign pushpull_mode_select = control[COGEN_CTRL_MODE_BIT];
   assign sw_clear_flag        = bus_in.wr && (bus_in.addr == COGEN_ADDR_SHUTDOWN)
                                 && !bus_in.wdata[COGEN_SHUT_FLAG_BIT];
   // flag already dropped: this rise ends the held shutdown
   assign resume               = !shutdown_flag && rise_ev;

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rising_event_source_select  <= COGEN_RESET_VALUE;
         falling_event_source_select <= COGEN_RESET_VALUE;
         auto_shutdown_control_0     <= COGEN_RESET_VALUE;
         control                     <= COGEN_RESET_VALUE;
         dead_rise                   <= COGEN_RESET_VALUE;
         dead_fall                   <= COGEN_RESET_VALUE;
         blank_rise                  <= COGEN_RESET_VALUE;
         blank_fall                  <= COGEN_RESET_VALUE;
         phase_count                 <= COGEN_RESET_VALUE;
         clk_div                     <= COGEN_RESET_VALUE;
      end else if (bus_in.wr) begin
         unique case (bus_in.addr)
            COGEN_ADDR_RISE_SEL:   rising_event_source_select <= bus_in.wdata & COGEN_RISE_MASK;
            COGEN_ADDR_SHUTDOWN:   auto_shutdown_control_0    <= bus_in.wdata & COGEN_SHUT_MASK;
            COGEN_ADDR_CONTROL:    control                    <= bus_in.wdata & COGEN_CTRL_MASK;
            COGEN_ADDR_FALL_SEL:   falling_event_source_select <= bus_in.wdata & COGEN_RISE_MASK;
            COGEN_ADDR_DEAD_RISE:  dead_rise                  <= bus_in.wdata;
            COGEN_ADDR_DEAD_FALL:  dead_fall                  <= bus_in.wdata;
            COGEN_ADDR_BLANK_RISE: blank_rise                 <= bus_in.wdata;
            COGEN_ADDR_BLANK_FALL: blank_fall                 <= bus_in.wdata;
            COGEN_ADDR_PHASE:      phase_count                <= bus_in.wdata;
            COGEN_ADDR_CLK_DIV:    clk_div                    <= bus_in.wdata;
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // register reads
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rdata_out <= COGEN_RESET_VALUE;
      end else if (bus_in.rd) begin
         unique case (bus_in.addr)
            COGEN_ADDR_RISE_SEL:   rdata_out <= rising_event_source_select;
            COGEN_ADDR_SHUTDOWN:   rdata_out <= {shutdown_flag, auto_shutdown_control_0[6:0]};
            COGEN_ADDR_CONTROL:    rdata_out <= control;
            COGEN_ADDR_FALL_SEL:   rdata_out <= falling_event_source_select;
            COGEN_ADDR_DEAD_RISE:  rdata_out <= dead_rise;
            COGEN_ADDR_DEAD_FALL:  rdata_out <= dead_fall;
            COGEN_ADDR_BLANK_RISE: rdata_out <= blank_rise;
            COGEN_ADDR_BLANK_FALL: rdata_out <= blank_fall;
            COGEN_ADDR_PHASE:      rdata_out <= phase_count;
            COGEN_ADDR_CLK_DIV:    rdata_out <= clk_div;
            default:               rdata_out <= COGEN_RESET_VALUE;
         endcase
      end else begin
         rdata_out <= COGEN_RESET_VALUE;
      end
   end

   // ------------------------------------------------------------
   // input synchronisers and edge detect
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         src_meta  <= '0;
         src_sync  <= '0;
         src_prev  <= '0;
         shut_meta <= 1'b0;
         shut_sync <= 1'b0;
      end else begin
         src_meta  <= event_src_in;
         src_sync  <= src_meta;
         src_prev  <= src_sync;
         shut_meta <= shutdown_src_in;
         shut_sync <= shut_meta;
      end
   end

   // one source may feed both rise and fall selects
   assign src_rise_edge = src_sync & ~src_prev;
   assign rise_ev = |(src_rise_edge & rising_event_source_select[6:0]);
   assign fall_ev = |(~src_sync & src_prev & falling_event_source_select[6:0]);

   // ------------------------------------------------------------
   // generator clock divider
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         div_cnt <= COGEN_COUNT_ZERO;
         tick    <= 1'b0;
      end else if (div_cnt >= clk_div) begin
         div_cnt <= COGEN_COUNT_ZERO;
         tick    <= 1'b1;
      end else begin
         div_cnt <= div_cnt + COGEN_COUNT_ONE;
         tick    <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // period sequencer: phase delay, drive, blanking
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state         <= COGEN_IDLE;
         phase_cnt     <= COGEN_COUNT_ZERO;
         blank_cnt     <= COGEN_COUNT_ZERO;
         blank_is_fall <= 1'b0;
         drive         <= 1'b0;
         steer         <= 1'b1;
      end else if (!enable || (shut_active && !resume)) begin
         state     <= COGEN_IDLE;
         drive     <= 1'b0;
         blank_cnt <= COGEN_COUNT_ZERO;
      end else begin
         if (tick && blank_cnt != COGEN_COUNT_ZERO) begin
            blank_cnt <= blank_cnt - COGEN_COUNT_ONE;
         end
         unique case (state)
            COGEN_IDLE: begin
               if (rise_ev && !(blank_is_fall && blank_cnt != COGEN_COUNT_ZERO)) begin
                  steer     <= ~steer;
                  phase_cnt <= phase_count;
                  state     <= COGEN_PHASE;
               end
            end
            COGEN_PHASE: begin
               if (phase_cnt == COGEN_COUNT_ZERO) begin
                  drive         <= 1'b1;
                  blank_cnt     <= blank_rise;
                  blank_is_fall <= 1'b0;
                  state         <= COGEN_ACTIVE;
               end else if (tick) begin
                  phase_cnt <= phase_cnt - COGEN_COUNT_ONE;
               end
            end
            COGEN_ACTIVE: begin
               if (fall_ev && !(!blank_is_fall && blank_cnt != COGEN_COUNT_ZERO)) begin
                  drive         <= 1'b0;
                  blank_cnt     <= blank_fall;
                  blank_is_fall <= 1'b1;
                  state         <= COGEN_IDLE;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // auto-shutdown
   // ------------------------------------------------------------
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         shutdown_flag <= 1'b0;
      end else if (shut_sync) begin
         shutdown_flag <= 1'b1;
      end else if (auto_shutdown_control_0[COGEN_SHUT_RESTART_BIT]) begin
         shutdown_flag <= 1'b0;
      end else if (sw_clear_flag) begin
         shutdown_flag <= 1'b0;
      end
   end

   // generator held until the next rise after the flag drops
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         shut_active <= 1'b0;
      end else if (shut_sync) begin
         shut_active <= 1'b1;
      end else if (resume) begin
         shut_active <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // mode steering and dead band
   // ------------------------------------------------------------
   always_comb begin
      if (pushpull_mode_select) begin
         want0 = drive && !steer;
         want1 = drive && steer;
      end else begin
         want0 = drive;
         want1 = !drive && (state != COGEN_PHASE) && enable;
      end
      next_ch0_on = want0 && !ch1_on && (dead0_cnt == COGEN_COUNT_ZERO);
      next_ch1_on = want1 && !ch0_on && (dead1_cnt == COGEN_COUNT_ZERO);
   end

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ch0_on    <= 1'b0;
         ch1_on    <= 1'b0;
         dead0_cnt <= COGEN_COUNT_ZERO;
         dead1_cnt <= COGEN_COUNT_ZERO;
      end else begin
         ch0_on <= next_ch0_on;
         ch1_on <= next_ch1_on;
         if (!want0) begin
            dead0_cnt <= dead_rise;
         end else if (tick && !ch1_on && dead0_cnt != COGEN_COUNT_ZERO) begin
            dead0_cnt <= dead0_cnt - COGEN_COUNT_ONE;
         end
         if (!want1) begin
            dead1_cnt <= dead_fall;
         end else if (tick && !ch0_on && dead1_cnt != COGEN_COUNT_ZERO) begin
            dead1_cnt <= dead1_cnt - COGEN_COUNT_ONE;
         end
      end
   end

   // ------------------------------------------------------------
   // output pins with shutdown override
   // ------------------------------------------------------------
   function automatic cogen_pin_s pin_value(input logic on, input logic pol, input logic shut,
                                            input logic [1:0] ovr);
      cogen_pin_s p;
      p.level = on ^ pol;
      p.oe_n  = 1'b0;
      if (shut) begin
         unique case (ovr)
            COGEN_OVR_TRISTATE: p.oe_n  = 1'b1;
            COGEN_OVR_INACTIVE: p.level = pol;
            COGEN_OVR_HIGH:     p.level = 1'b1;
            COGEN_OVR_LOW:      p.level = 1'b0;
         endcase
      end
      return p;
   endfunction

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         output_channel_0_out <= '{level: 1'b0, oe_n: 1'b1};
         output_channel_1_out <= '{level: 1'b0, oe_n: 1'b1};
      end else begin
         output_channel_0_out <= pin_value(next_ch0_on, control[COGEN_CTRL_POL0_BIT], shut_active,
                                 auto_shutdown_control_0[COGEN_SHUT_CH0_LO +: 2]);
         output_channel_1_out <= pin_value(next_ch1_on, control[COGEN_CTRL_POL1_BIT], shut_active,
                                 auto_shutdown_control_0[COGEN_SHUT_CH1_LO +: 2]);
      end
   end

endmodule

// ===== verification/cogen_top_sva.sv
// cogen_top_sva: port-level checks for the complementary generator
// assumes polarity bits stay 0 and only cogen_top ports are visible
`timescale 1ns/10ps
module cogen_top_sva
   import cogen_pkg::*;
(
   // clock and reset
   input wire logic                  clk_in,
   input wire logic                  reset_n_in,
   // register port
   input wire cogen_pkg::cogen_bus_s bus_in,
   input wire logic [7:0]            rdata_out,
   // channels
   input wire cogen_pkg::cogen_pin_s output_channel_0_out,
   input wire cogen_pkg::cogen_pin_s output_channel_1_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   idle_rdata_a: assert property (
      !$past(bus_in.rd) |-> rdata_out == 8'h00) else $error("read data not zero outside a read");
   rise_top_a: assert property (
      bus_in.rd && bus_in.addr == COGEN_ADDR_RISE_SEL |=> !rdata_out[7]) else $error("rise select top bit set");
   shut_low_a: assert property (
      bus_in.rd && bus_in.addr == COGEN_ADDR_SHUTDOWN |=> rdata_out[1:0] == 2'b00) else $error("shutdown low bits set");
   unmapped_read_a: assert property (
      bus_in.rd && bus_in.addr > COGEN_ADDR_CLK_DIV |=> rdata_out == 8'h00) else $error("unmapped read not zero");
   rise_readback_a: assert property (
      bus_in.wr && bus_in.addr == COGEN_ADDR_RISE_SEL ##1 bus_in.rd && bus_in.addr == COGEN_ADDR_RISE_SEL
      |=> rdata_out == ($past(bus_in.wdata, 2) & COGEN_RISE_MASK)) else $error("rise select readback wrong");
   no_overlap_a: assert property (
      !(output_channel_0_out.level && !output_channel_0_out.oe_n && output_channel_1_out.level
        && !output_channel_1_out.oe_n)) else $error("both channels driven on");
   ch0_gap_a: assert property (
      $rose(output_channel_0_out.level) && !output_channel_0_out.oe_n |-> !$past(output_channel_1_out.level))
      else $error("channel 0 on without gap");
   ch1_gap_a: assert property (
      $rose(output_channel_1_out.level) && !output_channel_1_out.oe_n |-> !$past(output_channel_0_out.level))
      else $error("channel 1 on without gap");
   // ------------------------------------------------------------
   // covers
   // ------------------------------------------------------------
   cover property ($rose(output_channel_0_out.level));
   cover property ($rose(output_channel_1_out.level));
   cover property (bus_in.rd && bus_in.addr == COGEN_ADDR_SHUTDOWN);
endmodule

bind cogen_top cogen_top_sva chk_u (
   .clk_in               (clk_in),
   .reset_n_in           (reset_n_in),
   .bus_in               (bus_in),
   .rdata_out            (rdata_out),
   .output_channel_0_out (output_channel_0_out),
   .output_channel_1_out (output_channel_1_out)
);

// ===== verification/cogen_feedback_model.sv
// cogen_feedback_model: driver stage with current-limit feedback
// assumes channel 0 drives the switch; feedback idles high, drops after a set on time
`timescale 1ns/10ps
module cogen_feedback_model
   import cogen_pkg::*;
#(
   parameter int FB_DELAY = 10
) (
   // clock and reset
   input  wire logic                  clk_in,
   input  wire logic                  reset_n_in,
   // switch drive and feedback
   input  wire cogen_pkg::cogen_pin_s drive_in,
   output logic                       fb_out
);
   int on_count;
   // on time counter, falling feedback ends the pulse
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         on_count <= 0;
      end else if (drive_in.level && !drive_in.oe_n) begin
         on_count <= (on_count < FB_DELAY) ? on_count + 1 : on_count;
      end else begin
         on_count <= 0;
      end
   end
   assign fb_out = (on_count < FB_DELAY);
endmodule

// ===== verification/tb_cogen_top.sv
// tb_cogen_top: self-checking bench for cogen_top with a driver stage model
// assumes the checker is bound by its own file; 50 MHz clock
`timescale 1ns/10ps
module tb_cogen_top;
   import cogen_pkg::*;
   typedef struct packed {
      logic [7:0] wr;
      logic [3:0] exp;
      logic [3:0] care;
   } cogen_row_s;
   localparam int FB_DELAY = 10;
   localparam cogen_row_s ROWS [0:3] = '{'{8'h9c, 4'h6, 4'h7}, '{8'ha0, 4'h0, 4'hf},
                                         '{8'h84, 4'h8, 4'hf}, '{8'h80, 4'h0, 4'hf}};
   logic       clk_in;
   logic       reset_n_in;
   cogen_bus_s bus_in;
   logic [7:0] rdata_out;
   logic [6:0] event_drive;
   logic       shutdown_src;
   logic       feedback;
   cogen_pin_s ch0_pin;
   cogen_pin_s ch1_pin;
   int         mismatches, compares, cycles, rise0, rise1, on0, b0, b1, bon;
   logic       last0, last1;

   cogen_top dut_u (
      .clk_in               (clk_in),
      .reset_n_in           (reset_n_in),
      .bus_in               (bus_in),
      .rdata_out            (rdata_out),
      .event_src_in         ({event_drive[6:1], event_drive[0] & feedback}),
      .shutdown_src_in      (shutdown_src),
      .output_channel_0_out (ch0_pin),
      .output_channel_1_out (ch1_pin)
   );
   cogen_feedback_model #(.FB_DELAY(FB_DELAY)) drv_u (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .drive_in   (ch0_pin),
      .fb_out     (feedback)
   );
   // ------------------------------------------------------------
   // clock, monitor, tasks
   // ------------------------------------------------------------
   initial begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end
   initial begin
      cycles = 0; rise0 = 0; rise1 = 0; on0 = 0; last0 = 1'b0; last1 = 1'b0;
   end
   always @(negedge clk_in) begin
      cycles = cycles + 1;
      if (ch0_pin.level === 1'b1 && last0 !== 1'b1) rise0 = rise0 + 1;
      if (ch1_pin.level === 1'b1 && last1 !== 1'b1) rise1 = rise1 + 1;
      if (ch0_pin.level === 1'b1) on0 = on0 + 1;
      last0 = ch0_pin.level;
      last1 = ch1_pin.level;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         conclude();
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares = compares + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic access(input logic [3:0] a, input logic [7:0] d, input bit w, input bit r, input logic [7:0] e);
      if (w) begin
         bus_in <= '{a, d, 1'b1, 1'b0};
         @(posedge clk_in);
      end
      if (r) begin
         bus_in <= '{a, 8'h00, 1'b0, 1'b1};
         @(posedge clk_in);
      end
      bus_in <= '0;
      #1;
      if (r) check(16'(rdata_out), 16'(e));
      @(posedge clk_in);
   endtask
   task automatic pwm(input int bit_n, input int n, input int hi, input int lo);
      for (int p = 0; p < n; p++) begin
         event_drive[bit_n] <= 1'b1;
         repeat (hi) @(posedge clk_in);
         event_drive[bit_n] <= 1'b0;
         repeat (lo) @(posedge clk_in);
      end
   endtask
   task automatic mark;
      b0 = rise0;
      b1 = rise1;
      bon = on0;
   endtask
   task automatic conclude;
      $display("counts: %0d compares, %0d mismatches", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      reset_n_in = 1'b0; bus_in = '0; event_drive = '0; shutdown_src = 1'b0; mismatches = 0; compares = 0;
      repeat (8) @(posedge clk_in);
      check(16'({ch0_pin, ch1_pin, rdata_out}), 16'({4'b0101, 8'h00}));
      reset_n_in <= 1'b1;
      @(posedge clk_in);
      access(COGEN_ADDR_RISE_SEL, 8'h00, 0, 1, 8'h00);
      access(COGEN_ADDR_SHUTDOWN, 8'h00, 0, 1, 8'h00);
      access(4'hf, 8'hff, 1, 1, 8'h00);
      access(COGEN_ADDR_RISE_SEL, 8'hff, 1, 1, 8'h7f);
      access(COGEN_ADDR_SHUTDOWN, 8'hff, 1, 1, 8'h7c);
      access(COGEN_ADDR_SHUTDOWN, 8'h00, 1, 0, 8'h00);
      $display("test registers done");
      access(COGEN_ADDR_RISE_SEL, 8'h04, 1, 0, 8'h00);
      access(COGEN_ADDR_FALL_SEL, 8'h04, 1, 0, 8'h00);
      access(COGEN_ADDR_CONTROL, 8'h01, 1, 0, 8'h00);
      @(posedge clk_in);
      mark();
      pwm(2, 4, 12, 20);
      check(16'(rise0 - b0), 16'h0004);
      check(16'(rise1 - b1), 16'h0004);
      check(16'(on0 - bon >= 44 && on0 - bon <= 52), 16'h0001);
      $display("test complementary done");
      access(COGEN_ADDR_CONTROL, 8'h03, 1, 0, 8'h00);
      mark();
      pwm(2, 1, 12, 20);
      check({8'(rise0 - b0), 8'(rise1 - b1)}, 16'h0100);
      pwm(2, 3, 12, 20);
      check({8'(rise0 - b0), 8'(rise1 - b1)}, 16'h0202);
      check(16'(on0 - bon >= 22 && on0 - bon <= 26), 16'h0001);
      $display("test push-pull done");
      access(COGEN_ADDR_CONTROL, 8'h01, 1, 0, 8'h00);
      for (int i = 0; i < 7; i++) begin
         access(COGEN_ADDR_RISE_SEL, 8'(1 << i), 1, 0, 8'h00);
         access(COGEN_ADDR_FALL_SEL, 8'(1 << i), 1, 0, 8'h00);
         mark();
         pwm(i, 1, 12, 20);
         pwm((i + 1) % 7, 1, 12, 20);
         check(16'(rise0 - b0), 16'h0001);
      end
      $display("test sources done");
      event_drive[0] <= 1'b1;
      access(COGEN_ADDR_RISE_SEL, 8'h04, 1, 0, 8'h00);
      access(COGEN_ADDR_FALL_SEL, 8'h01, 1, 0, 8'h00);
      mark();
      pwm(2, 2, 40, 20);
      check(16'(rise0 - b0), 16'h0002);
      check(16'(on0 - bon >= 2 * FB_DELAY && on0 - bon <= 2 * FB_DELAY + 12), 16'h0001);
      $display("test feedback done");
      access(COGEN_ADDR_FALL_SEL, 8'h04, 1, 0, 8'h00);
      access(COGEN_ADDR_PHASE, 8'h04, 1, 0, 8'h00);
      access(COGEN_ADDR_DEAD_RISE, 8'h03, 1, 0, 8'h00);
      mark();
      pwm(2, 1, 20, 20);
      check(16'(on0 - bon >= 11 && on0 - bon <= 13), 16'h0001);
      access(COGEN_ADDR_PHASE, 8'h00, 1, 0, 8'h00);
      access(COGEN_ADDR_DEAD_RISE, 8'h00, 1, 0, 8'h00);
      access(COGEN_ADDR_BLANK_RISE, 8'h1e, 1, 0, 8'h00);
      mark();
      pwm(2, 2, 20, 20);
      check({8'(rise0 - b0), 8'(on0 - bon >= 50 && on0 - bon <= 64)}, 16'h0101);
      access(COGEN_ADDR_BLANK_RISE, 8'h00, 1, 0, 8'h00);
      $display("test timing done");
      shutdown_src <= 1'b1;
      repeat (8) @(posedge clk_in);
      access(COGEN_ADDR_SHUTDOWN, 8'h00, 0, 1, 8'h80);
      for (int k = 0; k < 4; k++) begin
         access(COGEN_ADDR_SHUTDOWN, ROWS[k].wr, 1, 0, 8'h00);
         repeat (4) @(posedge clk_in);
         check(16'({ch0_pin, ch1_pin} & ROWS[k].care), 16'(ROWS[k].exp & ROWS[k].care));
         access(COGEN_ADDR_SHUTDOWN, 8'h00, 0, 1, (ROWS[k].wr | 8'h80) & 8'hfc);
      end
      shutdown_src <= 1'b0;
      repeat (10) @(posedge clk_in);
      access(COGEN_ADDR_SHUTDOWN, 8'h00, 0, 1, 8'h80);
      mark();
      pwm(2, 1, 12, 20);
      check(16'(rise0 - b0), 16'h0000);
      access(COGEN_ADDR_SHUTDOWN, 8'h00, 1, 1, 8'h00);
      pwm(2, 1, 40, 20);
      check(16'(rise0 - b0), 16'h0001);
      access(COGEN_ADDR_SHUTDOWN, 8'h40, 1, 0, 8'h00);
      shutdown_src <= 1'b1;
      repeat (8) @(posedge clk_in);
      access(COGEN_ADDR_SHUTDOWN, 8'h00, 0, 1, 8'hc0);
      shutdown_src <= 1'b0;
      repeat (8) @(posedge clk_in);
      access(COGEN_ADDR_SHUTDOWN, 8'h00, 0, 1, 8'h40);
      mark();
      pwm(2, 1, 12, 20);
      check(16'(rise0 - b0), 16'h0001);
      access(COGEN_ADDR_SHUTDOWN, 8'h00, 0, 1, 8'h40);
      $display("test shutdown done");
      conclude();
   end
endmodule
